// >>> rtl/spm_pkg.sv
package spm_pkg;
   localparam int GPIO_N = 4;
   // Interface mode straps {high, low}.
   localparam logic [1:0] MODE_SPI_MASTER = 2'h0;
   localparam logic [1:0] MODE_I2C_SLAVE  = 2'h1;
   localparam logic [1:0] MODE_SPI_SLAVE  = 2'h3;
   // Software register offsets of the device end.
   localparam logic [3:0] ADDR_STRAPS    = 4'h0;
   localparam logic [3:0] ADDR_CFG_ONE   = 4'h1;
   localparam logic [3:0] ADDR_CFG_TWO   = 4'h2;
   localparam logic [3:0] ADDR_PIN_STATE = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;
   localparam logic [3:0] ADDR_SHIFT     = 4'h6;
   localparam logic [3:0] ADDR_CTRL      = 4'h7;
   localparam logic [7:0] CFG_ONE_RST    = 8'h00;
   localparam logic [7:0] CFG_TWO_RST    = 8'h00;
   localparam logic [7:0] MASK_RST       = 8'h00;
   // Serial clock divider: half period in system cycles.
   localparam logic [7:0] SCLK_HALF      = 8'h04;
   localparam logic [3:0] BITS_PER_WORD  = 4'h8;
   typedef enum logic [1:0] {SPM_IDLE = 2'b00, SPM_SHIFT = 2'b01, SPM_DONE = 2'b11} spm_state_t;
endpackage : spm_pkg

// >>> rtl/spm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spm_link_if;
   logic [3:0] gpio_dev_o;
   logic [3:0] gpio_dev_oe;
   logic [3:0] gpio_host_o;
   logic [3:0] gpio_host_oe;
   logic       csn_dev_o;
   logic       csn_dev_oe;
   logic       csn_host_o;
   logic       csn_host_oe;
   logic       miso_dev_o;
   logic       miso_dev_oe;
   logic       miso_host_o;
   logic       miso_host_oe;
   logic       sclk_dev_o;
   logic       sclk_dev_oe;
   logic       sclk_host_o;
   logic       sclk_host_oe;
   logic       mosi_dev_o;
   logic       mosi_dev_oe;
   logic       mosi_host_o;
   logic       mosi_host_oe;
   logic       reset_n;
   logic [3:0] gpio;
   logic       serial_select_n;
   logic       miso;
   logic       sclk;
   logic       mosi;
   modport device (
      output gpio_dev_o, gpio_dev_oe, csn_dev_o, csn_dev_oe, miso_dev_o, miso_dev_oe,
      output sclk_dev_o, sclk_dev_oe, mosi_dev_o, mosi_dev_oe,
      input  reset_n, gpio, serial_select_n, miso, sclk, mosi
   );
   modport host (
      output gpio_host_o, gpio_host_oe, csn_host_o, csn_host_oe, miso_host_o, miso_host_oe,
      output sclk_host_o, sclk_host_oe, mosi_host_o, mosi_host_oe, reset_n,
      input  gpio, serial_select_n, miso, sclk, mosi
   );
endinterface : spm_link_if
`default_nettype wire

// >>> rtl/spm_device.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sample factory strap at reset rise.
// - Board holds factory strap normally low.
// - Factory strap becomes general pin three.
// - Autoconfig straps become general pins zero-two.
// - Pin state has live and latched bits.
// - Two mode straps pick host interface.
// - Host master drives select low per access.
// - Master mode drives select, then releases.
// - Select line released outside master mode.
// - Slave mode drives read data on MISO.
// - Master mode captures MISO from memory.
// - I2C master supplies the SCL clock.
// - SPI master supplies SCLK in slave mode.
// - Master mode drives SCLK during autoconfig.
// - Device drives no serial line in I2C mode.
// - MOSI carries commands from the master; master mode here holds MOSI low.
// - Straps latched into capture register.
// - Autoconfig straps select stored configuration.
module spm_device
   import spm_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST,
   spm_link_if.device      LINK,
   input  wire logic [3:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   output logic      [2:0] CONFIG_SEL,
   output logic            FACTORY_MODE,
   output logic            AUTOCFG_DONE,
   output logic            IRQ
);
   import spm_pkg::*;

   logic [3:0] gpio_s1_reg, gpio_s2_reg;
   logic [4:0] ctl_s1_reg, ctl_s2_reg;
   logic       chip_reset_low_s2_prev_reg;
   logic [5:0] strap_capture_reg;
   logic       straps_taken_reg;
   logic [7:0] gp_pin_config_one;
   logic [7:0] gp_pin_config_two;
   logic [3:0] gp_latched_reg;
   logic [7:0] irq_stat_reg, irq_mask_reg;
   logic [7:0] shift_reg, miso_word_reg;
   logic [7:0] div_reg;
   logic [3:0] bit_cnt_reg;
   logic       sclk_reg;
   logic       done_reg;
   logic       sclk_prev_reg;
   logic       word_evt;
   logic       tick;
   spm_state_t state_reg;
   logic [1:0] host_mode;
   logic       in_reset, chip_reset_low_rise;
   logic       s_sclk, s_csn, s_mosi;

   // Order of ctl synchroniser: {reset_n, csn, miso, sclk, mosi}.
   always_ff @(posedge CLK) begin
      gpio_s1_reg <= LINK.gpio;
      gpio_s2_reg <= gpio_s1_reg;
      ctl_s1_reg  <= {LINK.reset_n, LINK.serial_select_n, LINK.miso, LINK.sclk, LINK.mosi};
      ctl_s2_reg  <= ctl_s1_reg;
   end

   assign in_reset  = ~ctl_s2_reg[4];
   assign chip_reset_low_rise = ctl_s2_reg[4] & ~chip_reset_low_s2_prev_reg;
   assign s_sclk    = ctl_s2_reg[1];
   assign s_csn     = ctl_s2_reg[3];
   assign s_mosi    = ctl_s2_reg[0];
   assign host_mode = strap_capture_reg[5:4];

   always_ff @(posedge CLK) begin
      if (RST) begin
         chip_reset_low_s2_prev_reg <= 1'b0;
      end else begin
         chip_reset_low_s2_prev_reg <= ctl_s2_reg[4];
      end
   end

   // Layout {miso/IF1, csn/IF0, general_pin_three factory, gpio[2:0] autoconfig}.
   // strap capture
   always_ff @(posedge CLK) begin
      if (RST) begin
         strap_capture_reg <= 6'h00;
         straps_taken_reg  <= 1'b0;
      end else if (in_reset) begin
         // Follow the pins while reset is low: once the synchronised release arrives
         // the pins already play their run-time roles, so the last value is kept.
         straps_taken_reg  <= 1'b0;
         strap_capture_reg <= {ctl_s2_reg[2], ctl_s2_reg[3], gpio_s2_reg};
      end else if (chip_reset_low_rise && !straps_taken_reg) begin
         straps_taken_reg  <= 1'b1;
      end
   end

   assign FACTORY_MODE = strap_capture_reg[3];
   assign CONFIG_SEL   = strap_capture_reg[2:0];

   // pins zero-three role
   // Config one: [1:0] drive value, [5:4] output enable for pins 0..1;
   // pin2_function_field and pin3_function_field live in config two.
   genvar gi;
   generate
      for (gi = 0; gi < GPIO_N; gi++) begin : g_pin
         logic en;
         logic val;
         if (gi < 2) begin : g_low
            assign en  = gp_pin_config_one[gi+4];
            assign val = gp_pin_config_one[gi];
         end else if (gi == 2) begin : g_two
            assign en  = gp_pin_config_two[1];
            assign val = gp_pin_config_two[0];
         end else begin : g_three
            assign en  = gp_pin_config_two[5];
            assign val = gp_pin_config_two[4];
         end
         assign LINK.gpio_dev_o[gi]  = val;
         assign LINK.gpio_dev_oe[gi] = en & straps_taken_reg & ~in_reset;
      end
   endgenerate

   always_ff @(posedge CLK) begin
      if (RST) begin
         gp_latched_reg <= 4'h0;
      end else if (RD && ADDR == ADDR_PIN_STATE) begin
         gp_latched_reg <= gpio_s2_reg;
      end else begin
         gp_latched_reg <= gp_latched_reg | gpio_s2_reg;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         div_reg <= 8'h00;
      end else if (div_reg == SCLK_HALF - 8'h01) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   assign tick = (div_reg == SCLK_HALF - 8'h01);

   // Master-mode autoconfig read: one byte clocked in from the memory.
   // select driven
   always_ff @(posedge CLK) begin
      if (RST || in_reset) begin
         state_reg   <= SPM_IDLE;
         sclk_reg    <= 1'b0;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         done_reg    <= 1'b0;
      end else begin
         unique case (state_reg)
            SPM_IDLE: begin
               if (straps_taken_reg && host_mode == MODE_SPI_MASTER && !done_reg
                   && !FACTORY_MODE) begin
                  // Start on a tick so the select leads the first clock edge by a half period.
                  state_reg   <= tick ? SPM_SHIFT : SPM_IDLE;
                  bit_cnt_reg <= 4'h0;
               end else if (straps_taken_reg) begin
                  done_reg <= 1'b1;
               end
            end
            SPM_SHIFT: begin
               if (tick) begin
                  sclk_reg <= ~sclk_reg;
                  if (!sclk_reg) begin
                     shift_reg   <= {shift_reg[6:0], ctl_s2_reg[2]};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (bit_cnt_reg == BITS_PER_WORD) begin
                     state_reg <= SPM_DONE;
                  end
               end
            end
            SPM_DONE: begin
               done_reg  <= 1'b1;
               state_reg <= SPM_IDLE;
            end
         endcase
      end
   end
   assign AUTOCFG_DONE = done_reg;

   logic master_active;
   assign master_active = (state_reg == SPM_SHIFT);
   assign LINK.csn_dev_o   = 1'b0;
   assign LINK.csn_dev_oe  = master_active;
   assign LINK.sclk_dev_o  = sclk_reg;
   assign LINK.sclk_dev_oe = master_active;
   assign LINK.mosi_dev_o  = 1'b0;
   assign LINK.mosi_dev_oe = master_active;

   // Slave mode: host writes arrive on MOSI, reads return on MISO.
   // host clock
   always_ff @(posedge CLK) begin
      if (RST) begin
         sclk_prev_reg <= 1'b0;
         miso_word_reg <= 8'h00;
      end else begin
         sclk_prev_reg <= s_sclk;
         if (host_mode == MODE_SPI_SLAVE && !s_csn && s_sclk && !sclk_prev_reg) begin
            miso_word_reg <= {miso_word_reg[6:0], s_mosi};
         end
      end
   end
   assign word_evt = host_mode == MODE_SPI_SLAVE && s_csn == 1'b0 && s_sclk && !sclk_prev_reg;
   assign LINK.miso_dev_o  = miso_word_reg[7];
   assign LINK.miso_dev_oe = (host_mode == MODE_SPI_SLAVE) && !s_csn && straps_taken_reg;

   always_ff @(posedge CLK) begin
      if (RST) begin
         gp_pin_config_one <= CFG_ONE_RST;
         gp_pin_config_two <= CFG_TWO_RST;
         irq_mask_reg      <= MASK_RST;
      end else if (WR) begin
         if (ADDR == ADDR_CFG_ONE) gp_pin_config_one <= WDATA;
         if (ADDR == ADDR_CFG_TWO) gp_pin_config_two <= WDATA;
         if (ADDR == ADDR_IRQ_MASK) irq_mask_reg <= WDATA;
      end
   end

   // Events: [0] straps taken, [1] autoconfig done, [2] slave bit, [7:4] pin high.
   logic [7:0] evt;
   assign evt = {gpio_s2_reg, 1'b0, word_evt, state_reg == SPM_DONE, chip_reset_low_rise};
   always_ff @(posedge CLK) begin
      if (RST) begin
         irq_stat_reg <= 8'h00;
      end else if (RD && ADDR == ADDR_IRQ_STAT) begin
         irq_stat_reg <= evt;
      end else begin
         irq_stat_reg <= irq_stat_reg | evt;
      end
   end
   assign IRQ = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         unique case (ADDR)
            ADDR_STRAPS:    RDATA <= {2'h0, strap_capture_reg};
            ADDR_CFG_ONE:   RDATA <= gp_pin_config_one;
            ADDR_CFG_TWO:   RDATA <= gp_pin_config_two;
            ADDR_PIN_STATE: RDATA <= {gp_latched_reg, gpio_s2_reg};
            ADDR_IRQ_STAT:  RDATA <= irq_stat_reg;
            ADDR_IRQ_MASK:  RDATA <= irq_mask_reg;
            ADDR_SHIFT:     RDATA <= shift_reg;
            ADDR_CTRL:      RDATA <= {6'h00, done_reg, straps_taken_reg};
            default:        RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end
endmodule : spm_device
`default_nettype wire

// >>> rtl/spm_host.sv
`timescale 1ns/1ps
`default_nettype none
module spm_host
   import spm_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST,
   spm_link_if.host        LINK,
   input  wire logic       CHIP_RESET_LOW,
   input  wire logic [5:0] STRAPS,
   input  wire logic       SEL_N,
   input  wire logic       SCLK_IN,
   input  wire logic       MOSI_IN,
   output logic            MISO_BIT
);
   import spm_pkg::*;

   logic [1:0] miso_s_reg;
   logic       in_reset;

   always_ff @(posedge CLK) begin
      if (RST) begin
         miso_s_reg <= 2'h0;
      end else begin
         miso_s_reg <= {miso_s_reg[0], LINK.miso};
      end
   end
   assign MISO_BIT = miso_s_reg[1];

   assign LINK.reset_n = CHIP_RESET_LOW;
   assign in_reset     = ~CHIP_RESET_LOW;

   // select driven in reset, released between accesses
   // Straps are driven only while reset is held, then pins are released.
   assign LINK.gpio_host_o  = STRAPS[3:0];
   assign LINK.gpio_host_oe = {4{in_reset}};
   assign LINK.csn_host_o   = in_reset ? STRAPS[4] : SEL_N;
   // select for accesses
   // Released while not selecting, so a device in master mode can own the line.
   assign LINK.csn_host_oe  = in_reset | ~SEL_N;
   // After reset the host answers a select it did not make, acting as the memory.
   assign LINK.miso_host_o  = in_reset ? STRAPS[5] : MOSI_IN;
   assign LINK.miso_host_oe = in_reset | (SEL_N & ~LINK.serial_select_n);
   assign LINK.sclk_host_o  = SCLK_IN;
   assign LINK.sclk_host_oe = ~in_reset & ~SEL_N;
   assign LINK.mosi_host_o  = MOSI_IN;
   assign LINK.mosi_host_oe = ~in_reset & ~SEL_N;
endmodule : spm_host
`default_nettype wire

// >>> tb/spm_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spm_link_checker (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       reset_n,
   input wire logic [3:0] gpio_dev_oe,
   input wire logic       serial_select_n,
   input wire logic       csn_dev_o,
   input wire logic       csn_dev_oe,
   input wire logic       csn_host_oe,
   input wire logic       miso_dev_oe,
   input wire logic       miso_host_oe,
   input wire logic       sclk_dev_o,
   input wire logic       sclk_dev_oe,
   input wire logic       sclk_host_oe,
   input wire logic       mosi_dev_o,
   input wire logic       mosi_dev_oe,
   input wire logic       mosi_host_o,
   input wire logic       mosi_host_oe
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_sclk_edge;
      sclk_dev_oe && $changed(sclk_dev_o);
   endsequence
   sequence s_sclk_hold;
      (!sclk_dev_oe || $stable(sclk_dev_o)) [*3];
   endsequence
   a_quiet_in_reset:
      assert property ((!reset_n) [*5] |-> gpio_dev_oe == 4'h0 && !csn_dev_oe && !miso_dev_oe)
      else $error("device drives a strap pin in reset");
   a_csn_no_fight:
      assert property (!(csn_dev_oe && csn_host_oe)) else $error("select driven twice");
   a_sclk_no_fight:
      assert property (!(sclk_dev_oe && sclk_host_oe)) else $error("clock driven twice");
   a_miso_no_fight:
      assert property (!(miso_dev_oe && miso_host_oe)) else $error("miso driven twice");
   a_mosi_no_fight:
      assert property (!(mosi_dev_oe && mosi_host_oe && mosi_dev_o != mosi_host_o))
      else $error("mosi driven to two levels");
   a_sclk_half_period:
      assert property (s_sclk_edge |=> s_sclk_hold) else $error("serial clock half period short");
   a_sclk_in_select:
      assert property (s_sclk_edge |-> csn_dev_oe && !csn_dev_o)
      else $error("serial clock outside select");
   a_miso_needs_select:
      assert property ((serial_select_n) [*4] |-> !miso_dev_oe) else $error("miso driven while deselected");
endmodule : spm_link_checker
`default_nettype wire

// >>> tb/spm_device_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spm_device_tb;
   import spm_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       chip_rst_n = 1'b0;
   logic [5:0] straps = 6'h00;
   logic       sel_n = 1'b1;
   logic       sclk_in = 1'b1;
   logic       mosi_in = 1'b1;
   logic [3:0] gp_pull = 4'h0;
   logic       miso_idle = 1'b0;
   logic [7:0] rdata, v;
   logic [2:0] config_sel;
   logic       factory_mode, autocfg_done, irq, miso_bit, saw_sel, saw_clk, saw_miso;
   int         num_errors = 0;
   int         checks_done = 0;
   spm_link_if link ();
   // Undriven select, clock and data lines are pulled up; miso has no pull.
   assign link.serial_select_n = (link.csn_dev_oe ? link.csn_dev_o : 1'b1) & (link.csn_host_oe ? link.csn_host_o : 1'b1);
   assign link.sclk = (link.sclk_dev_oe ? link.sclk_dev_o : 1'b1) & (link.sclk_host_oe ? link.sclk_host_o : 1'b1);
   assign link.mosi = (link.mosi_dev_oe ? link.mosi_dev_o : 1'b1) & (link.mosi_host_oe ? link.mosi_host_o : 1'b1);
   assign link.miso = link.miso_dev_oe ? link.miso_dev_o : link.miso_host_oe ? link.miso_host_o : miso_idle;
   assign link.gpio = (link.gpio_dev_oe & link.gpio_dev_o) | (~link.gpio_dev_oe & link.gpio_host_oe & link.gpio_host_o)
                    | (~link.gpio_dev_oe & ~link.gpio_host_oe & gp_pull);
   spm_device u_spm_device (.CLK(clk), .RST(rst), .LINK(link.device), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .CONFIG_SEL(config_sel), .FACTORY_MODE(factory_mode),
      .AUTOCFG_DONE(autocfg_done), .IRQ(irq));
   spm_host u_spm_host (.CLK(clk), .RST(rst), .LINK(link.host), .CHIP_RESET_LOW(chip_rst_n),
      .STRAPS(straps), .SEL_N(sel_n), .SCLK_IN(sclk_in), .MOSI_IN(mosi_in), .MISO_BIT(miso_bit));
   spm_link_checker u_spm_link_checker (.CLK(clk), .RST(rst), .reset_n(link.reset_n),
      .gpio_dev_oe(link.gpio_dev_oe), .serial_select_n(link.serial_select_n), .csn_dev_o(link.csn_dev_o),
      .csn_dev_oe(link.csn_dev_oe), .csn_host_oe(link.csn_host_oe), .miso_dev_oe(link.miso_dev_oe),
      .miso_host_oe(link.miso_host_oe), .sclk_dev_o(link.sclk_dev_o), .sclk_dev_oe(link.sclk_dev_oe),
      .sclk_host_oe(link.sclk_host_oe), .mosi_dev_o(link.mosi_dev_o), .mosi_dev_oe(link.mosi_dev_oe),
      .mosi_host_o(link.mosi_host_o), .mosi_host_oe(link.mosi_host_oe));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      miso_idle <= ~miso_idle;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask : reg_rd
   // Chip reset is held low well beyond the minimum so the straps settle.
   task automatic strap(input logic [5:0] s);
      chip_rst_n <= 1'b0;
      straps <= s;
      repeat (40) @(posedge clk);
      chip_rst_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : strap
   task automatic t_straps();
      for (int i = 0; i < 8; i++) begin
         strap({MODE_I2C_SLAVE, i[0], i[2:0]});
         check("config_sel", {5'h00, i[2:0]}, {5'h00, config_sel});
         check("factory", {7'h00, i[0]}, {7'h00, factory_mode});
         check("sclk_oe", 8'h00, {7'h00, link.sclk_dev_oe});
         straps <= ~straps;
         gp_pull <= ~gp_pull;
         repeat (8) @(posedge clk);
         check("config_held", {5'h00, i[2:0]}, {5'h00, config_sel});
      end
      $display("test straps done");
   endtask : t_straps
   task automatic t_master();
      strap({MODE_SPI_MASTER, 4'h0});
      saw_sel = 1'b0;
      saw_clk = 1'b0;
      saw_miso = 1'b0;
      for (int n = 0; n < 20000 && autocfg_done !== 1'b1; n++) begin
         @(posedge clk);
         saw_sel |= link.csn_dev_oe && !link.serial_select_n;
         saw_clk |= link.sclk_dev_oe;
         saw_miso |= link.miso_dev_oe;
      end
      check("done", 8'h01, {7'h00, autocfg_done});
      check("sel_low", 8'h01, {7'h00, saw_sel});
      check("clk_out", 8'h01, {7'h00, saw_clk});
      check("miso_in", 8'h00, {7'h00, saw_miso});
      repeat (4) @(posedge clk);
      check("sel_input", 8'h00, {7'h00, link.csn_dev_oe});
      reg_rd(ADDR_SHIFT, v);
      check("shift_byte", 8'hff, v);
      $display("test master done");
   endtask : t_master
   task automatic t_slave();
      logic [7:0] rx;
      rx = 8'h00;
      strap({MODE_SPI_SLAVE, 4'h0});
      sel_n <= 1'b0;
      // Two bytes of 8'h33 go out; while the second is sent the first comes back.
      for (int b = 0; b < 32; b++) begin
         repeat (4) @(posedge clk);
         if (b[0]) begin
            rx = {rx[6:0], miso_bit};
         end
         sclk_in <= ~sclk_in;
         mosi_in <= b[2];
         check("slv_oe", 8'h00, {6'h00, link.csn_dev_oe, link.sclk_dev_oe});
      end
      check("miso_word", 8'h33, rx);
      repeat (4) @(posedge clk);
      sel_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("miso_off", 8'h00, {7'h00, link.miso_dev_oe});
      $display("test slave done");
   endtask : t_slave
   task automatic t_regs();
      reg_rd(ADDR_CFG_ONE, v);
      check("cfg_one", CFG_ONE_RST, v);
      reg_rd(ADDR_CFG_TWO, v);
      check("cfg_two", CFG_TWO_RST, v);
      reg_rd(4'h8, v);
      check("unmapped", 8'h00, v);
      reg_wr(ADDR_IRQ_MASK, 8'hff);
      reg_rd(ADDR_IRQ_MASK, v);
      check("mask", 8'hff, v);
      gp_pull <= 4'ha;
      repeat (6) @(posedge clk);
      reg_rd(ADDR_PIN_STATE, v);
      check("live", 8'h0a, {4'h0, v[3:0]});
      check("irq_high", 8'h01, {7'h00, irq});
      // Pin events follow the level, so the pins go low before the status is cleared.
      gp_pull <= 4'h0;
      repeat (4) @(posedge clk);
      reg_rd(ADDR_IRQ_STAT, v);
      reg_rd(ADDR_IRQ_STAT, v);
      check("stat_clr", 8'h00, v);
      check("irq_low", 8'h00, {7'h00, irq});
      $display("test regs done");
   endtask : t_regs
   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial begin
      #1500000;
      num_errors++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_straps();
      t_master();
      t_slave();
      t_regs();
      results();
   end
endmodule : spm_device_tb
`default_nettype wire
